//--- logic/period_timer_pkg.sv
/*
  Shared constants and carrier types for the three-channel 8-bit period timer.
  Assumes a single core clock domain and software writes as one-cycle strobes.
*/
package period_timer_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_TIMERS = 3;
  localparam int CNT_W = 8;
  localparam int PRE_W = 7;
  localparam int PRE_SEL_W = 3;
  localparam int POST_W = 4;
  localparam int MODE_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [CNT_W-1:0] COUNT_RST = 8'h00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [MODE_W-1:0] MODE_RST = 5'h00;
  localparam logic [PRE_W-1:0] PRE_ONE = 7'h01;

  // ****************************************
  // Mode field layout and codes
  // ****************************************
  localparam int MODE_CLASS_HI = 4;
  localparam int MODE_CLASS_LO = 3;
  localparam int MODE_SUB_HI = 2;
  localparam int MODE_SUB_LO = 0;

  localparam logic [1:0] CLASS_FREE = 2'h0;
  localparam logic [1:0] CLASS_ONESHOT = 2'h1;
  localparam logic [1:0] CLASS_MONO = 2'h2;

  localparam logic [2:0] SUB_SOFT = 3'h0;
  localparam logic [2:0] SUB_GATE_HI = 3'h1;
  localparam logic [2:0] SUB_GATE_LO = 3'h2;
  localparam logic [2:0] SUB_ANY_EDGE = 3'h3;
  localparam logic [2:0] SUB_RISE = 3'h4;
  localparam logic [2:0] SUB_FALL = 3'h5;
  localparam logic [2:0] SUB_LOW_LVL = 3'h6;
  localparam logic [2:0] SUB_HIGH_LVL = 3'h7;

  // ****************************************
  // Carrier types
  // ****************************************
  typedef struct packed {
    logic timer_run_bit;
    logic [PRE_SEL_W-1:0] prescale_sel;
    logic [POST_W-1:0] postscale_match_field;
  } control_reg_t;

  typedef struct packed {
    logic count_wr;
    logic [CNT_W-1:0] count_data;
    logic control_wr;
    control_reg_t control_data;
    logic period_wr;
    logic [CNT_W-1:0] period_data;
    logic limit_wr;
    logic [MODE_W-1:0] limit_mode;
    logic flag_clr;
  } sw_req_t;

  typedef struct packed {
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] period_reg;
    logic timer_run_bit;
    logic postscaled_pulse;
    logic period_flag;
  } timer_status_t;

endpackage

//--- logic/ers_sync.sv
/*
  Two-stage synchroniser for one asynchronous input (an external reset signal or the debug freeze level).
  Assumes the input may change at any time relative to core_clk.
*/
`timescale 1ns/1ns
`default_nettype none

module ers_sync (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic async_in,
  output logic sync_out
);

  logic meta_r;
  logic stable_r;

  // ****************************************
  // Synchroniser chain
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      meta_r <= 1'b0;
      stable_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;

endmodule

`default_nettype wire

//--- logic/eight_bit_period_timer.sv
/*
  Three identical 8-bit period timers with prescaler, shadowed period,
  postscaler, hardware gate/reset modes, one-shot and monostable operation.
  Assumes software strobes arrive on core_clk; external reset signals and the
  debug freeze level may be asynchronous and are synchronised here.
*/
`timescale 1ns/1ns
`default_nettype none

module eight_bit_period_timer
  import period_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic debug_freeze,
  input wire logic [NUM_TIMERS-1:0] external_reset_signal,
  input wire sw_req_t [NUM_TIMERS-1:0] sw_req,
  output var timer_status_t [NUM_TIMERS-1:0] status
);

  logic freeze_sync;

  // ****************************************
  // Debug freeze synchroniser
  // ****************************************
  ers_sync u_freeze_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(debug_freeze),
    .sync_out(freeze_sync)
  );

  // ****************************************
  // Timer channels
  // ****************************************
  genvar ch;
  generate
    for (ch = 0; ch < NUM_TIMERS; ch = ch + 1) begin : g_timer

      typedef enum logic [1:0] {
        ST_IDLE,
        ST_RUN,
        ST_DONE
      } run_state_t;

      run_state_t state_r;
      run_state_t state_nxt;

      logic ers_level;
      logic ers_hold_r;
      logic ers_prev_r;
      logic ers_rise;
      logic ers_fall;
      logic ers_any;

      logic [CNT_W-1:0] count_r;
      logic [CNT_W-1:0] count_nxt;
      logic [CNT_W-1:0] period_r;
      logic [CNT_W-1:0] shadow_r;
      logic [MODE_W-1:0] mode_r;
      control_reg_t ctrl_r;
      logic run_r;
      logic run_nxt;
      logic [PRE_W-1:0] pre_r;
      logic [PRE_W-1:0] pre_max;
      logic [POST_W-1:0] post_r;
      logic [POST_W-1:0] post_nxt;
      logic pulse_r;
      logic flag_r;

      logic [1:0] mode_class;
      logic [2:0] mode_sub;
      logic is_free;
      logic is_oneshot;
      logic is_mono;
      logic is_level_mode;
      logic soft_start;
      logic start_edge;
      logic start_hit;
      logic reset_evt;
      logic gate_ok;
      logic tick;
      logic match;
      logic count_en;
      logic period_evt;
      logic post_hit;
      logic scaler_clr;
      logic shadow_load;

      // ****************************************
      // External reset input path
      // ****************************************
      ers_sync u_ers_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in(external_reset_signal[ch]),
        .sync_out(ers_level)
      );

      // Frozen level is held so no edge or level change is seen
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          ers_hold_r <= 1'b0;
          ers_prev_r <= 1'b0;
        end else begin
          ers_hold_r <= freeze_sync ? ers_hold_r : ers_level;
          ers_prev_r <= ers_hold_r;
        end
      end

      assign ers_rise = ers_hold_r & ~ers_prev_r;
      assign ers_fall = ~ers_hold_r & ers_prev_r;
      assign ers_any = ers_rise | ers_fall;

      // ****************************************
      // Mode decode
      // ****************************************
      assign mode_class = mode_r[MODE_CLASS_HI:MODE_CLASS_LO];
      assign mode_sub = mode_r[MODE_SUB_HI:MODE_SUB_LO];
      assign is_free = (mode_class == CLASS_FREE);
      assign is_oneshot = (mode_class == CLASS_ONESHOT);
      assign is_mono = (mode_class == CLASS_MONO) &&
                       ((mode_sub == SUB_GATE_HI) || (mode_sub == SUB_GATE_LO) ||
                        (mode_sub == SUB_ANY_EDGE));
      assign is_level_mode = (mode_class == CLASS_MONO) && (mode_sub == SUB_LOW_LVL);

      // Start condition for triggered modes
      assign soft_start = is_oneshot && (mode_sub == SUB_SOFT);
      assign start_edge =
        (mode_sub == SUB_GATE_HI) ? ers_rise :
        (mode_sub == SUB_GATE_LO) ? ers_fall :
        (mode_sub == SUB_ANY_EDGE) ? ers_any :
        (mode_sub == SUB_RISE) ? ers_rise :
        (mode_sub == SUB_FALL) ? ers_fall :
        (mode_sub == SUB_LOW_LVL) ? (is_oneshot ? ers_rise : ers_hold_r) :
        (mode_sub == SUB_HIGH_LVL) ? ers_fall :
        1'b0;
      assign start_hit = soft_start | ((is_oneshot | is_mono | is_level_mode) & start_edge);

      // Hardware reset condition of the count
      assign reset_evt = run_r & (
        (is_free && (mode_sub == SUB_ANY_EDGE) && ers_any) ||
        ((is_free || is_oneshot) && (mode_sub == SUB_RISE) && ers_rise) ||
        ((is_free || is_oneshot) && (mode_sub == SUB_FALL) && ers_fall) ||
        ((is_free || is_oneshot || is_level_mode) && (mode_sub == SUB_LOW_LVL) &&
         !ers_hold_r) ||
        ((is_free || is_oneshot) && (mode_sub == SUB_HIGH_LVL) && ers_hold_r));

      // Hardware gate in free-running gate modes
      assign gate_ok =
        (is_free && (mode_sub == SUB_GATE_HI)) ? ers_hold_r :
        (is_free && (mode_sub == SUB_GATE_LO)) ? !ers_hold_r :
        1'b1;

      // ****************************************
      // Prescaler
      // ****************************************
      assign pre_max = PRE_W'((PRE_ONE << ctrl_r.prescale_sel) - PRE_ONE);
      assign tick = (pre_r == pre_max);

      assign scaler_clr = sw_req[ch].count_wr | sw_req[ch].control_wr | reset_evt;

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          pre_r <= '0;
        end else if (scaler_clr) begin
          pre_r <= '0;
        end else begin
          pre_r <= tick ? '0 : PRE_W'(pre_r + PRE_ONE);
        end
      end

      // ****************************************
      // Count and period compare
      // ****************************************
      assign match = (count_r == shadow_r);
      assign count_en = (state_r == ST_RUN) && tick && gate_ok && !reset_evt;
      assign period_evt = count_en && match;

      always_comb begin
        count_nxt = count_r;
        if (sw_req[ch].count_wr) begin
          count_nxt = sw_req[ch].count_data;
        end else if (reset_evt) begin
          count_nxt = COUNT_RST;
        end else if (period_evt) begin
          count_nxt = COUNT_RST;
        end else if (count_en) begin
          count_nxt = CNT_W'(count_r + 8'h01);
        end
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          count_r <= COUNT_RST;
        end else begin
          count_r <= count_nxt;
        end
      end

      // ****************************************
      // Period register and shadow
      // ****************************************
      assign shadow_load = sw_req[ch].count_wr | sw_req[ch].control_wr | reset_evt |
                           (match & tick);

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          period_r <= PERIOD_RST;
          shadow_r <= PERIOD_RST;
        end else begin
          if (sw_req[ch].period_wr) begin
            period_r <= sw_req[ch].period_data;
          end
          if (shadow_load) begin
            shadow_r <= period_r;
          end
        end
      end

      // ****************************************
      // Postscaler, pulse and flag
      // ****************************************
      assign post_hit = (post_r == ctrl_r.postscale_match_field);

      always_comb begin
        post_nxt = post_r;
        if (scaler_clr) begin
          post_nxt = '0;
        end else if (period_evt) begin
          post_nxt = post_hit ? '0 : POST_W'(post_r + 4'h1);
        end
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          post_r <= '0;
          pulse_r <= 1'b0;
          flag_r <= 1'b0;
        end else begin
          post_r <= post_nxt;
          if (scaler_clr) begin
            pulse_r <= 1'b0;
          end else if (tick) begin
            pulse_r <= period_evt & post_hit;
          end
          if (period_evt & post_hit) begin
            flag_r <= 1'b1;
          end else if (sw_req[ch].flag_clr) begin
            flag_r <= 1'b0;
          end
        end
      end

      // ****************************************
      // Control, mode and run bit
      // ****************************************
      always_comb begin
        run_nxt = run_r;
        if (sw_req[ch].control_wr) begin
          run_nxt = sw_req[ch].control_data.timer_run_bit;
        end else if (is_oneshot && period_evt) begin
          run_nxt = 1'b0;
        end
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          ctrl_r <= '0;
          mode_r <= MODE_RST;
          run_r <= 1'b0;
        end else begin
          if (sw_req[ch].control_wr) begin
            ctrl_r <= sw_req[ch].control_data;
          end
          if (sw_req[ch].limit_wr) begin
            mode_r <= sw_req[ch].limit_mode;
          end
          run_r <= run_nxt;
        end
      end

      // ****************************************
      // Run state
      // ****************************************
      always_comb begin
        state_nxt = state_r;
        if (!run_r) begin
          state_nxt = ST_IDLE;
        end else begin
          unique case (state_r)
            ST_IDLE: begin
              if (is_free || start_hit) begin
                state_nxt = ST_RUN;
              end
            end
            ST_RUN: begin
              if (is_level_mode && !ers_hold_r) begin
                state_nxt = ST_IDLE;
              end else if (period_evt && is_oneshot) begin
                state_nxt = ST_DONE;
              end else if (period_evt && is_mono) begin
                state_nxt = ST_IDLE;
              end
            end
            ST_DONE: begin
              state_nxt = ST_DONE;
            end
          endcase
        end
      end

      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          state_r <= ST_IDLE;
        end else begin
          state_r <= state_nxt;
        end
      end

      // ****************************************
      // Status outputs
      // ****************************************
      assign status[ch].count_reg = count_r;
      assign status[ch].period_reg = period_r;
      assign status[ch].timer_run_bit = run_r;
      assign status[ch].postscaled_pulse = pulse_r;
      assign status[ch].period_flag = flag_r;

    end
  endgenerate

endmodule

`default_nettype wire

//--- verif/period_timer_checker.sv
/*
  Port checker for timer channel 0 of the period timer.
  Assumes one core clock domain and an active-high asynchronous reset.
*/
`timescale 1ns/1ns
`default_nettype none

module period_timer_checker
  import period_timer_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic debug_freeze,
  input wire logic [NUM_TIMERS-1:0] external_reset_signal,
  input wire sw_req_t [NUM_TIMERS-1:0] sw_req,
  input wire timer_status_t [NUM_TIMERS-1:0] status
);
  // ****************************************
  // Channel view and mode tracking
  // ****************************************
  sw_req_t q;
  timer_status_t s;
  logic [MODE_W-1:0] mode_r;
  assign q = sw_req[0];
  assign s = status[0];
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mode_r <= MODE_RST;
    end else if (q.limit_wr) begin
      mode_r <= q.limit_mode;
    end
  end

  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_pulse_rise;
    $rose(s.postscaled_pulse);
  endsequence
  property p_count_wr;
    q.count_wr |=> s.count_reg == $past(q.count_data);
  endproperty
  property p_count_step;
    $changed(s.count_reg) && !$past(q.count_wr) |->
      s.count_reg == $past(s.count_reg) + 8'h01 || s.count_reg == COUNT_RST;
  endproperty
  property p_ctl_keep;
    q.control_wr && !q.count_wr && !s.timer_run_bit |=> $stable(s.count_reg);
  endproperty
  property p_run_wr;
    q.control_wr |=> s.timer_run_bit == $past(q.control_data.timer_run_bit);
  endproperty
  property p_period_wr;
    q.period_wr |=> s.period_reg == $past(q.period_data);
  endproperty
  property p_period_hold;
    !q.period_wr |=> $stable(s.period_reg);
  endproperty
  property p_pulse_zero;
    s_pulse_rise |-> s.count_reg == COUNT_RST;
  endproperty
  property p_flag_set;
    s_pulse_rise |-> s.period_flag;
  endproperty
  property p_flag_clr;
    q.flag_clr |=> !s.period_flag || $rose(s.postscaled_pulse);
  endproperty
  property p_flag_hold;
    s.period_flag && !q.flag_clr |=> s.period_flag;
  endproperty
  property p_run_fall;
    $fell(s.timer_run_bit) && !$past(q.control_wr) |->
      mode_r[MODE_CLASS_HI:MODE_CLASS_LO] == CLASS_ONESHOT;
  endproperty
  a_count_wr: assert property (p_count_wr)
    else $error("count write lost");
  a_count_step: assert property (p_count_step)
    else $error("count jumped");
  a_ctl_keep: assert property (p_ctl_keep)
    else $error("control write moved count");
  a_run_wr: assert property (p_run_wr)
    else $error("run bit write lost");
  a_period_wr: assert property (p_period_wr)
    else $error("period write lost");
  a_period_hold: assert property (p_period_hold)
    else $error("period changed without write");
  a_pulse_zero: assert property (p_pulse_zero)
    else $error("pulse without reload");
  a_flag_set: assert property (p_flag_set)
    else $error("flag not set by pulse");
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag not cleared");
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag dropped");
  a_run_fall: assert property (p_run_fall)
    else $error("run bit cleared outside one-shot");
endmodule

bind eight_bit_period_timer period_timer_checker u_chk (
  .core_clk(core_clk),
  .rst(rst),
  .debug_freeze(debug_freeze),
  .external_reset_signal(external_reset_signal),
  .sw_req(sw_req),
  .status(status)
);

`default_nettype wire

//--- verif/ers_source.sv
/*
  Peripheral model: drives the external reset levels and counts pulses.
  Assumes the timer clock equals the core clock when edges are spaced.
*/
`timescale 1ns/1ns
`default_nettype none

module ers_source
  import period_timer_pkg::*;
#(
  parameter int HOLD = 6
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [NUM_TIMERS-1:0] level_req,
  input wire logic [NUM_TIMERS-1:0] pulse,
  output logic [NUM_TIMERS-1:0] ers_r,
  output logic [NUM_TIMERS-1:0][7:0] pulse_cnt_r
);
  logic [NUM_TIMERS-1:0][3:0] age_r;
  logic [NUM_TIMERS-1:0] prev_r;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ers_r <= '0;
      age_r <= '0;
      prev_r <= '0;
      pulse_cnt_r <= '0;
    end else begin
      prev_r <= pulse;
      for (int i = 0; i < NUM_TIMERS; i++) begin
        if (level_req[i] != ers_r[i] && age_r[i] >= 4'(HOLD)) begin
          ers_r[i] <= level_req[i];
          age_r[i] <= 4'h0;
        end else if (age_r[i] != 4'hF) begin
          age_r[i] <= age_r[i] + 4'h1;
        end
        if (pulse[i] && !prev_r[i]) begin
          pulse_cnt_r[i] <= pulse_cnt_r[i] + 8'h01;
        end
      end
    end
  end
endmodule

`default_nettype wire

//--- verif/testbench.sv
/*
  Self-checking bench for the three-channel period timer.
  Assumes the peripheral model in ers_source and the bound port checker.
*/
`timescale 1ns/1ns
`default_nettype none

module testbench;
  import period_timer_pkg::*;
  typedef struct {int ch; logic [7:0] per; logic [2:0] sel; logic [3:0] post; int gap;} row_t;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic core_clk;
  logic rst;
  logic debug_freeze;
  logic [NUM_TIMERS-1:0] lvl;
  logic [NUM_TIMERS-1:0] ers;
  logic [NUM_TIMERS-1:0] pulse;
  logic [NUM_TIMERS-1:0][7:0] pcnt;
  sw_req_t [NUM_TIMERS-1:0] sw_req;
  timer_status_t [NUM_TIMERS-1:0] status;
  int n_fail;
  int comparisons;
  row_t rows [6] = '{'{0, 8'h02, 3'h0, 4'h0, 3}, '{1, 8'h05, 3'h1, 4'h1, 24},
    '{2, 8'h03, 3'h7, 4'h0, 512}, '{0, 8'h00, 3'h0, 4'h3, 4},
    '{1, 8'hFF, 3'h0, 4'h0, 256}, '{2, 8'h01, 3'h2, 4'hF, 128}};
  always_comb begin
    for (int i = 0; i < NUM_TIMERS; i++) pulse[i] = status[i].postscaled_pulse;
  end
  eight_bit_period_timer u_eight_bit_period_timer (.core_clk(core_clk), .rst(rst),
    .debug_freeze(debug_freeze), .external_reset_signal(ers), .sw_req(sw_req),
    .status(status));
  ers_source u_ers_source (.core_clk(core_clk), .rst(rst), .level_req(lvl), .pulse(pulse),
    .ers_r(ers), .pulse_cnt_r(pcnt));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input int ch, input int k, input logic [7:0] d);
    sw_req_t r;
    r = '0;
    r.count_data = d;
    r.control_data = control_reg_t'(d);
    r.period_data = d;
    r.limit_mode = d[MODE_W-1:0];
    r.count_wr = (k == 0);
    r.control_wr = (k == 1);
    r.period_wr = (k == 2);
    r.limit_wr = (k == 3);
    r.flag_clr = (k == 4);
    @(negedge core_clk);
    sw_req[ch] = r;
    @(negedge core_clk);
    sw_req[ch] = '0;
  endtask
  task automatic wait_pulse(input int ch, output int n);
    logic p;
    p = status[ch].postscaled_pulse;
    n = 0;
    while (n < 3000) begin
      @(negedge core_clk);
      n++;
      if (status[ch].postscaled_pulse === 1'b1 && p === 1'b0) break;
      p = status[ch].postscaled_pulse;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Clock, watchdog and main sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    n_fail++;
    complete_run();
  end
  initial begin
    int n;
    logic [7:0] c;
    rst = 1'b1;
    debug_freeze = 1'b0;
    lvl = '0;
    sw_req = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    for (int i = 0; i < NUM_TIMERS; i++) begin
      chk({status[i].count_reg, status[i].period_reg}, {COUNT_RST, PERIOD_RST});
      chk({status[i].timer_run_bit, status[i].period_flag}, 2'b00);
    end
    foreach (rows[i]) begin
      wr(rows[i].ch, 3, 8'h00);
      wr(rows[i].ch, 2, rows[i].per);
      wr(rows[i].ch, 1, {1'b1, rows[i].sel, rows[i].post});
      wait_pulse(rows[i].ch, n);
      chk(status[rows[i].ch].period_flag, 1'b1);
      wait_pulse(rows[i].ch, n);
      chk(n, rows[i].gap);
      wr(rows[i].ch, 4, 8'h00);
      chk(status[rows[i].ch].period_flag, 1'b0);
      wr(rows[i].ch, 1, 8'h00);
    end
    // Shadow keeps old period until the next match
    wr(0, 0, 8'h00);
    wr(0, 2, 8'h40);
    wr(0, 1, 8'h80);
    wr(0, 2, 8'h03);
    for (int i = 0; i < 40 && status[0].count_reg !== 8'h10; i++) cyc(1);
    chk(status[0].count_reg, 8'h10);
    wait_pulse(0, n);
    wait_pulse(0, n);
    chk(n, 4);
    wr(0, 1, 8'h00);
    wr(0, 0, 8'hA5);
    wr(0, 1, 8'h00);
    chk(status[0].count_reg, 8'hA5);
    // One-shot stop and restart
    wr(0, 0, 8'h00);
    wr(0, 3, 8'h08);
    wr(0, 1, 8'h80);
    wait_pulse(0, n);
    cyc(2);
    chk(status[0].timer_run_bit, 1'b0);
    c = pcnt[0];
    cyc(30);
    chk(pcnt[0], c);
    wr(0, 1, 8'h00);
    wr(0, 1, 8'h80);
    wait_pulse(0, n);
    chk(n < 20, 1'b1);
    // Gate high holds and resumes
    wr(0, 3, 8'h01);
    wr(0, 2, 8'hFF);
    wr(0, 0, 8'h00);
    wr(0, 1, 8'h80);
    cyc(10);
    chk(status[0].count_reg, 8'h00);
    lvl[0] = 1'b1;
    cyc(20);
    lvl[0] = 1'b0;
    cyc(12);
    c = status[0].count_reg;
    cyc(10);
    chk(status[0].count_reg, c);
    lvl[0] = 1'b1;
    cyc(12);
    chk(status[0].count_reg > c, 1'b1);
    // Rising edge reset, then ignored under freeze
    wr(0, 3, 8'h04);
    lvl[0] = 1'b0;
    cyc(10);
    wr(0, 0, 8'h80);
    cyc(2);
    lvl[0] = 1'b1;
    cyc(10);
    chk(status[0].count_reg < 8'h10, 1'b1);
    debug_freeze = 1'b1;
    cyc(4);
    lvl[0] = 1'b0;
    cyc(8);
    lvl[0] = 1'b1;
    cyc(10);
    chk(status[0].count_reg > 8'h18, 1'b1);
    debug_freeze = 1'b0;
    // Monostable restarts on a new edge
    lvl[0] = 1'b0;
    cyc(8);
    wr(0, 1, 8'h00);
    wr(0, 2, 8'h03);
    wr(0, 3, 8'h11);
    wr(0, 0, 8'h00);
    wr(0, 1, 8'h80);
    lvl[0] = 1'b1;
    wait_pulse(0, n);
    chk(n < 30, 1'b1);
    cyc(3);
    chk(status[0].timer_run_bit, 1'b1);
    c = pcnt[0];
    lvl[0] = 1'b0;
    cyc(8);
    lvl[0] = 1'b1;
    wait_pulse(0, n);
    cyc(2);
    chk(pcnt[0], c + 8'h01);
    complete_run();
  end
endmodule

`default_nettype wire
